// File: hw/fcs_status_branch.sv
`timescale 1ns/1ps

// Function
// - Field 100 nearest-even, 0xx uses global field.
// - Fields 111 floor, 110 ceiling, 101 truncate.
// - Most-recent exception flags in bits 6..0.
// - Sticky exception copies in bits 14..8 accumulate.
// - Ordering relations in bits 19..16 from compares.
// - Classify results in bits 28..24, classify only.
// - Software writing ones never raises an exception.
// - Signaling NaN raises invalid except classify and silent ops.
// - Compare sets exactly one ordering bit.
// - Signaling compare: any NaN unordered plus invalid.
// - Quiet compare: quiet NaN unordered, no invalid.
// - Quiet compare: signaling NaN unordered plus invalid.
// - Compare minuend minus subtrahend sets relation.
// - Unordered takes precedence over equal.
// - Negative and positive zero compare equal.
// - Status updates at completion of each operation except silent ops.
// - Sixteen-bit predicate vector; selected bit decides branch.
// - Predicate withheld until in-flight compares retire.
// - Even predicate bits encode relations, odd negate.
// - Classify leaves ordering bits and exceptions alone.
// - Speculative FPU instructions accepted and discardable.
// - One-cycle kill abandons first-slot instruction.
// - Subnormal operand sets tiny flag when mode off, except classify and silent ops.
module fcs_status_branch (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire fcs_pkg::fcs_issue_s issue,
    input wire logic [2:0] convRndField,
    input wire logic [1:0] globalRnd,
    input wire logic tinyAsZeroMode,
    input wire logic [fcs_pkg::EXC_W-1:0] excMask,
    input wire logic cpuKill,
    input wire logic [fcs_pkg::EXC_W-1:0] dpExc,
    input wire logic fsrWrEn,
    input wire logic [fcs_pkg::FSR_W-1:0] fsrWrData,
    input wire logic branchReq,
    input wire logic [fcs_pkg::PRED_SEL_W-1:0] branchSel,
    output logic [fcs_pkg::FSR_W-1:0] fsrRdData,
    output logic [2:0] convRound,
    output logic excRaise,
    output logic [fcs_pkg::EXC_W-1:0] excCause,
    output logic [fcs_pkg::PRED_W-1:0] predVector,
    output logic predReady,
    output logic cpuStall,
    output logic branchTaken
);
    import fcs_pkg::*;

    // ************************************************************
    // Operand inspection
    // ************************************************************
    typedef struct packed {
        logic isNan;
        logic isSnan;
        logic isZero;
        logic isTiny;
        logic isEndless;
        logic isNeg;
    } fcs_kind_s;

    function automatic fcs_kind_s fcs_inspect(input logic [31:0] v);
        fcs_kind_s k;
        logic expOnes;
        logic expZero;
        logic fracZero;
        expOnes = &v[30:23];
        expZero = ~|v[30:23];
        fracZero = ~|v[22:0];
        k.isNan = expOnes & ~fracZero;
        k.isSnan = expOnes & ~fracZero & ~v[22];
        k.isZero = expZero & fracZero;
        k.isTiny = expZero & ~fracZero;
        k.isEndless = expOnes & fracZero;
        k.isNeg = v[31];
        return k;
    endfunction

    fcs_kind_s kindM;
    fcs_kind_s kindS;
    logic anyNan;
    logic anySnan;
    logic anyTiny;
    logic cmpEq;
    logic cmpGt;
    logic [ORDER_W-1:0] orderNew;
    logic [EXC_W-1:0] excNew;
    fcs_entry_s entryNew;
    fcs_entry_s pipe [PIPE_STAGES];
    fcs_entry_s retireEntry;
    logic retire;
    logic [FSR_W-1:0] fpu_status_flags;
    logic [FSR_W-1:0] next_fsr;
    logic [EXC_W-1:0] retireExc;
    logic [PIPE_STAGES-1:0] cmpInFlight;

    assign kindM = fcs_inspect(issue.minuend);
    assign kindS = fcs_inspect(issue.subtrahend);
    assign anyNan = kindM.isNan | kindS.isNan;
    assign anySnan = kindM.isSnan | kindS.isSnan;
    assign anyTiny = kindM.isTiny | kindS.isTiny;

    // Sign-magnitude ordering; both zeros are one value regardless of sign.
    always_comb begin
        cmpEq = (issue.minuend == issue.subtrahend) | (kindM.isZero & kindS.isZero);
        if (kindM.isZero & kindS.isZero) begin
            cmpGt = 1'b0;
        end else if (issue.minuend[31] != issue.subtrahend[31]) begin
            cmpGt = ~issue.minuend[31];
        end else if (issue.minuend[31]) begin
            cmpGt = issue.minuend[30:0] < issue.subtrahend[30:0];
        end else begin
            cmpGt = issue.minuend[30:0] > issue.subtrahend[30:0];
        end
    end

    // Unordered is decided first so a NaN equal to itself never reads equal.
    always_comb begin
        orderNew = '0;
        if (anyNan) begin
            orderNew[NO_ORDER_BIT] = 1'b1;
        end else if (cmpEq) begin
            orderNew[SAME_BIT] = 1'b1;
        end else if (cmpGt) begin
            orderNew[GREATER_BIT] = 1'b1;
        end else begin
            orderNew[LESS_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // Status effects decided at issue
    // ************************************************************
    always_comb begin
        excNew = '0;
        entryNew = '0;
        entryNew.valid = issue.valid;
        entryNew.order = orderNew;
        entryNew.cls[CLS_TINY_BIT] = kindM.isTiny;
        entryNew.cls[CLS_ENDLESS_BIT] = kindM.isEndless;
        entryNew.cls[CLS_ZERO_BIT] = kindM.isZero;
        entryNew.cls[CLS_NEG_BIT] = kindM.isNeg;
        entryNew.cls[CLS_NAN_BIT] = kindM.isNan;
        excNew[TINY_OP_BIT] = anyTiny & ~tinyAsZeroMode;
        case (issue.op)
            FCS_OP_ARITH, FCS_OP_CONVERT: begin
                excNew[BAD_OP_BIT] = anySnan;
                entryNew.updExc = 1'b1;
            end
            FCS_OP_SIG_CMP: begin
                excNew[BAD_OP_BIT] = anyNan;
                entryNew.updExc = 1'b1;
                entryNew.updOrder = 1'b1;
                entryNew.isCompare = 1'b1;
            end
            FCS_OP_QUIET_CMP: begin
                excNew[BAD_OP_BIT] = anySnan;
                entryNew.updExc = 1'b1;
                entryNew.updOrder = 1'b1;
                entryNew.isCompare = 1'b1;
            end
            FCS_OP_CLASSIFY: begin
                excNew = '0;
                entryNew.updClass = 1'b1;
            end
            default: begin
                excNew = '0;
            end
        endcase
        entryNew.exc = excNew;
    end

    // ************************************************************
    // Rounding select for conversions
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            convRound <= RND_NEAREST;
        end else if (issue.valid && issue.op == FCS_OP_CONVERT) begin
            if (convRndField[RND_EXPLICIT_BIT]) begin
                convRound <= convRndField;
            end else begin
                convRound <= {1'b1, globalRnd};
            end
        end
    end

    // ************************************************************
    // Retire pipeline
    // ************************************************************
    // Speculative instructions ride the pipe like any other; the kill
    // clears the entry passing into the second stage so nothing of it reaches the status.
    for (genvar i = 0; i < PIPE_STAGES; i++) begin : gStage
        if (i == 0) begin : gHead
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    pipe[i] <= '0;
                end else begin
                    pipe[i] <= entryNew;
                end
            end
        end else begin : gTail
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    pipe[i] <= '0;
                end else begin
                    pipe[i] <= pipe[i-1];
                    if (i == 1 && cpuKill) begin
                        pipe[i].valid <= 1'b0;
                    end
                end
            end
        end
        assign cmpInFlight[i] = pipe[i].valid & pipe[i].isCompare;
    end

    assign retireEntry = pipe[PIPE_STAGES-1];
    assign retire = retireEntry.valid;
    assign retireExc = retireEntry.exc | dpExc;

    // ************************************************************
    // Status register
    // ************************************************************
    // A retiring operation wins over a software write in the same cycle,
    // so no hardware-set flag can be lost to a concurrent clear.
    always_comb begin
        next_fsr = fpu_status_flags;
        if (fsrWrEn) begin
            next_fsr = fsrWrData & FSR_WR_MASK;
        end
        if (retire && retireEntry.updExc) begin
            next_fsr[EXC_LO +: EXC_W] = retireExc;
            next_fsr[STICKY_LO +: EXC_W] = next_fsr[STICKY_LO +: EXC_W] | retireExc;
        end
        if (retire && retireEntry.updOrder) begin
            next_fsr[ORDER_LO +: ORDER_W] = retireEntry.order;
        end
        if (retire && retireEntry.updClass) begin
            next_fsr[CLASS_LO +: CLASS_W] = retireEntry.cls;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fpu_status_flags <= FSR_RESET;
        end else begin
            fpu_status_flags <= next_fsr;
        end
    end

    assign fsrRdData = fpu_status_flags;

    // Only a retiring operation can raise; software writes never reach here.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            excRaise <= 1'b0;
            excCause <= '0;
        end else begin
            excRaise <= retire & retireEntry.updExc & |(retireExc & ~excMask);
            excCause <= (retire && retireEntry.updExc) ? (retireExc & ~excMask) : '0;
        end
    end

    // ************************************************************
    // Branch predicates
    // ************************************************************
    logic [ORDER_W-1:0] ord;
    logic [PRED_PAIRS-1:0] predEven;

    assign ord = fpu_status_flags[ORDER_LO +: ORDER_W];
    assign predEven[0] = ord[SAME_BIT];
    assign predEven[1] = ord[GREATER_BIT] | ord[LESS_BIT];
    assign predEven[2] = ord[GREATER_BIT];
    assign predEven[3] = ord[GREATER_BIT] | ord[SAME_BIT];
    assign predEven[4] = ord[LESS_BIT];
    assign predEven[5] = ord[LESS_BIT] | ord[SAME_BIT];
    assign predEven[6] = ~ord[NO_ORDER_BIT];

    // The top pair has no predicate behind it and reads as zero.
    always_comb begin
        predVector = '0;
        for (int p = 0; p < PRED_PAIRS; p++) begin
            predVector[2*p] = predEven[p];
            predVector[2*p+1] = ~predEven[p];
        end
    end

    // A compare issuing this cycle already counts as underway.
    assign predReady = ~(|cmpInFlight) & ~(entryNew.valid & entryNew.isCompare);
    assign cpuStall = branchReq & ~predReady;
    assign branchTaken = branchReq & predReady & predVector[branchSel];

    // ************************************************************
    // Checks
    // ************************************************************
    a_order_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (retire && retireEntry.updOrder) |=> $onehot(fpu_status_flags[ORDER_LO +: ORDER_W]))
        else $error("compare did not leave exactly one ordering bit");

    a_nan_unordered: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue.valid && issue.op == FCS_OP_QUIET_CMP && anyNan && !cpuKill)
        ##1 !cpuKill |-> ##3 fpu_status_flags[ORDER_LO + NO_ORDER_BIT] && !fpu_status_flags[ORDER_LO + SAME_BIT])
        else $error("NaN compare did not read unordered");

    a_sticky_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(fsrWrEn) |-> (($past(fpu_status_flags[STICKY_LO +: EXC_W]) & ~fpu_status_flags[STICKY_LO +: EXC_W]) == '0))
        else $error("sticky flag dropped without a write");

    a_classify_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (retire && retireEntry.updClass && !fsrWrEn)
        |=> $stable(fpu_status_flags[ORDER_LO +: ORDER_W]) && $stable(fpu_status_flags[STICKY_LO +: EXC_W]))
        else $error("classify disturbed ordering or sticky bits");

    a_pred_negate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (predVector[1] == ~predVector[0]) && (predVector[13] == ~predVector[12])
        && (predVector[12] == ~fpu_status_flags[ORDER_LO + NO_ORDER_BIT]))
        else $error("predicate pair mismatch");

    a_branch_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue.valid && issue.op == FCS_OP_SIG_CMP && branchReq) |-> cpuStall ##1 cpuStall)
        else $error("branch not held behind in-flight compare");

    a_sw_no_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        excRaise |-> $past(retire) && $past(retireEntry.updExc))
        else $error("exception raised without a retiring operation");

    a_kill_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpuKill |=> !pipe[1].valid ##1 !retire)
        else $error("killed instruction reached retirement");

    a_round_near: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue.valid && issue.op == FCS_OP_CONVERT && convRndField == RND_NEAREST)
        |=> convRound == RND_NEAREST)
        else $error("field 100 did not select nearest");

    a_silent_op: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (retire && !retireEntry.updExc && !retireEntry.updClass && !fsrWrEn)
        |=> $stable(fpu_status_flags))
        else $error("silent operation changed status");

    a_tiny_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue.valid && issue.op == FCS_OP_ARITH && anyTiny && !tinyAsZeroMode && !cpuKill)
        ##1 !cpuKill |-> ##3 fpu_status_flags[EXC_LO + TINY_OP_BIT] && fpu_status_flags[STICKY_LO + TINY_OP_BIT])
        else $error("subnormal operand not flagged");

endmodule

// File: hw/fcs_pkg.sv
package fcs_pkg;

    // ************************************************************
    // Status register layout
    // ************************************************************
    localparam int FSR_W = 32;
    localparam int EXC_W = 7;
    localparam int EXC_LO = 0;
    localparam int STICKY_LO = 8;
    localparam int ORDER_LO = 16;
    localparam int CLASS_LO = 24;
    localparam int ORDER_W = 4;
    localparam int CLASS_W = 5;
    localparam logic [FSR_W-1:0] FSR_RESET = 32'h0000_0000;
    localparam logic [FSR_W-1:0] FSR_WR_MASK = 32'h1f0f_7f7f;

    // Exception bit positions within a seven-bit group.
    localparam int INEXACT_BIT = 6;
    localparam int HUGE_INT_BIT = 5;
    localparam int OVERFLOW_BIT = 4;
    localparam int UNDERFLOW_BIT = 3;
    localparam int DIV_ZERO_BIT = 2;
    localparam int BAD_OP_BIT = 1;
    localparam int TINY_OP_BIT = 0;

    // Ordering relation positions within the four-bit group.
    localparam int GREATER_BIT = 3;
    localparam int LESS_BIT = 2;
    localparam int SAME_BIT = 1;
    localparam int NO_ORDER_BIT = 0;

    // Classify positions within the five-bit group.
    localparam int CLS_TINY_BIT = 4;
    localparam int CLS_ENDLESS_BIT = 3;
    localparam int CLS_ZERO_BIT = 2;
    localparam int CLS_NEG_BIT = 1;
    localparam int CLS_NAN_BIT = 0;

    // ************************************************************
    // Predicates, rounding and pipeline
    // ************************************************************
    localparam int PRED_W = 16;
    localparam int PRED_SEL_W = 4;
    localparam int PRED_PAIRS = 7;
    localparam int PIPE_STAGES = 3;

    localparam logic [2:0] RND_FLOOR = 3'h7;
    localparam logic [2:0] RND_CEIL = 3'h6;
    localparam logic [2:0] RND_TRUNC = 3'h5;
    localparam logic [2:0] RND_NEAREST = 3'h4;
    localparam int RND_EXPLICIT_BIT = 2;

    typedef enum logic [2:0] {
        FCS_OP_ARITH,
        FCS_OP_CONVERT,
        FCS_OP_SIG_CMP,
        FCS_OP_QUIET_CMP,
        FCS_OP_CLASSIFY,
        FCS_OP_SILENT
    } fcs_op_e;

    typedef struct packed {
        logic valid;
        fcs_op_e op;
        logic [31:0] minuend;
        logic [31:0] subtrahend;
    } fcs_issue_s;

    typedef struct packed {
        logic valid;
        logic isCompare;
        logic updExc;
        logic updOrder;
        logic updClass;
        logic [EXC_W-1:0] exc;
        logic [ORDER_W-1:0] order;
        logic [CLASS_W-1:0] cls;
    } fcs_entry_s;

endpackage

// File: sim/fcs_cpu_model.sv
`timescale 1ns/1ps

// ************************************************************
// Integer pipeline model issuing, killing and branching
// ************************************************************
module fcs_cpu_model (
    input wire logic ref_clk,
    input wire logic cpuStall,
    input wire logic branchTaken,
    output fcs_pkg::fcs_issue_s issue,
    output logic [2:0] convRndField,
    output logic cpuKill,
    output logic [fcs_pkg::EXC_W-1:0] dpExc,
    output logic branchReq,
    output logic [fcs_pkg::PRED_SEL_W-1:0] branchSel
);
    import fcs_pkg::*;

    // Only the first speculative slot is ever issued, so a second slot never reaches write-back.
    initial begin
        issue = '0;
        convRndField = 3'h0;
        cpuKill = 1'h0;
        dpExc = '0;
        branchReq = 1'h0;
        branchSel = '0;
    end

    task automatic send(input fcs_op_e op, input logic [31:0] a, input logic [31:0] b,
            input logic [2:0] rf, input logic kill, input logic [EXC_W-1:0] dp);
        @(posedge ref_clk);
        #1;
        issue = '{valid: 1'h1, op: op, minuend: a, subtrahend: b};
        convRndField = rf;
        @(posedge ref_clk);
        #1;
        issue.valid = 1'h0;
        cpuKill = kill;
        @(posedge ref_clk);
        #1;
        cpuKill = 1'h0;
        @(posedge ref_clk);
        #1;
        dpExc = dp;
        @(posedge ref_clk);
        #1;
        dpExc = '0;
    endtask

    // The stall is sampled one step after the request lands so that a same-cycle issue counts.
    task automatic branch(input logic [2:0] opc, input logic sub, output logic taken,
            output int stalls);
        @(posedge ref_clk);
        #1;
        branchSel = {opc, sub};
        branchReq = 1'h1;
        stalls = 0;
        #1;
        while (cpuStall !== 1'h0 && stalls < 10) begin
            @(posedge ref_clk);
            #2;
            stalls++;
        end
        taken = branchTaken;
        @(posedge ref_clk);
        #1;
        branchReq = 1'h0;
    endtask
endmodule

// File: sim/fcs_status_branch_tb.sv
`timescale 1ns/1ps

module fcs_status_branch_tb;
    import fcs_pkg::*;

    typedef struct {
        fcs_op_e op;
        logic [31:0] a;
        logic [31:0] b;
        logic [3:0] order;
        logic bad;
    } fcs_row_s;

    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    fcs_issue_s issue;
    logic [2:0] convRndField;
    logic [1:0] globalRnd = 2'h1;
    logic tinyAsZeroMode = 1'h0;
    logic [EXC_W-1:0] excMask = '0;
    logic cpuKill;
    logic [EXC_W-1:0] dpExc;
    logic fsrWrEn = 1'h0;
    logic [FSR_W-1:0] fsrWrData = '0;
    logic branchReq;
    logic [PRED_SEL_W-1:0] branchSel;
    logic [FSR_W-1:0] fsrRdData;
    logic [2:0] convRound;
    logic excRaise;
    logic [EXC_W-1:0] excCause;
    logic [PRED_W-1:0] predVector;
    logic predReady;
    logic cpuStall;
    logic branchTaken;
    int fails = 0;
    int n_checks = 0;
    int nRaise = 0;
    int expRaise = 0;
    logic tk;
    int st;
    logic [3:0] idx;
    logic [15:0] pv;
    logic sticky = 1'h0;
    logic [2:0] expRnd;
    logic [FSR_W-1:0] fsrSnap;
    fcs_row_s rows [8] = '{
        '{FCS_OP_SIG_CMP, 32'h4000_0000, 32'h3f80_0000, 4'h8, 1'h0},
        '{FCS_OP_QUIET_CMP, 32'h3f80_0000, 32'h4000_0000, 4'h4, 1'h0},
        '{FCS_OP_SIG_CMP, 32'h8000_0000, 32'h0000_0000, 4'h2, 1'h0},
        '{FCS_OP_QUIET_CMP, 32'h7fc0_0000, 32'h3f80_0000, 4'h1, 1'h0},
        '{FCS_OP_QUIET_CMP, 32'h7fa0_0000, 32'h3f80_0000, 4'h1, 1'h1},
        '{FCS_OP_SIG_CMP, 32'h7fc0_0000, 32'h7fc0_0000, 4'h1, 1'h1},
        '{FCS_OP_SIG_CMP, 32'hbf80_0000, 32'hc000_0000, 4'h8, 1'h0},
        '{FCS_OP_QUIET_CMP, 32'h7f80_0000, 32'h7f80_0000, 4'h2, 1'h0}
    };

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (excRaise === 1'h1) begin
            nRaise++;
        end
    end

    fcs_status_branch i_fcs_status_branch (
        .ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .convRndField(convRndField),
        .globalRnd(globalRnd), .tinyAsZeroMode(tinyAsZeroMode), .excMask(excMask),
        .cpuKill(cpuKill), .dpExc(dpExc), .fsrWrEn(fsrWrEn), .fsrWrData(fsrWrData),
        .branchReq(branchReq), .branchSel(branchSel), .fsrRdData(fsrRdData),
        .convRound(convRound), .excRaise(excRaise), .excCause(excCause),
        .predVector(predVector), .predReady(predReady), .cpuStall(cpuStall),
        .branchTaken(branchTaken)
    );

    fcs_cpu_model i_fcs_cpu_model (
        .ref_clk(ref_clk), .cpuStall(cpuStall), .branchTaken(branchTaken), .issue(issue),
        .convRndField(convRndField), .cpuKill(cpuKill), .dpExc(dpExc),
        .branchReq(branchReq), .branchSel(branchSel)
    );

    // ************************************************************
    // Expectations and reporting
    // ************************************************************
    function automatic logic [15:0] pred_of(input logic [3:0] o);
        logic [6:0] e;
        logic [15:0] v;
        e = {~o[0], o[3] | o[1], o[2], o[3] | o[2], o[3], o[3] | o[1], o[1]};
        e = {e[6], o[2] | o[1], o[2], o[3] | o[1], o[3], o[3] | o[2], o[1]};
        v = '0;
        for (int k = 0; k < 7; k++) begin
            v[2*k] = e[k];
            v[2*k+1] = ~e[k];
        end
        return v;
    endfunction

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1) begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        settle(20);
        rst_n = 1'h1;
        check(fsrRdData === 32'h0 && convRound === 3'h4, "reset state");
        check(predVector === pred_of(4'h0) && predReady === 1'h1, "reset predicates");
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            idx = 4'((i * 3) % 16);
            fork
                i_fcs_cpu_model.send(rows[i].op, rows[i].a, rows[i].b, 3'h0, 1'h0, '0);
                i_fcs_cpu_model.branch(idx[3:1], idx[0], tk, st);
            join
            if (st >= 10) begin
                fails++;
                give_verdict();
            end
            settle(2);
            sticky = sticky | rows[i].bad;
            expRaise += int'(rows[i].bad);
            pv = pred_of(rows[i].order);
            check(st == 4, "branch stall length");
            check(fsrRdData[19:16] === rows[i].order, "ordering bits");
            check(fsrRdData[1] === rows[i].bad, "invalid flag");
            check(fsrRdData[9] === sticky, "invalid sticky");
            check(predVector === pv, "predicate vector");
            check(tk === pv[idx], "branch decision");
        end
        check(nRaise === expRaise, "compare exception pulses");
        $display("compare table test done");
        for (int f = 0; f < 8; f++) begin
            i_fcs_cpu_model.send(FCS_OP_CONVERT, 32'h3f80_0000, 32'h3f80_0000, 3'(f), 1'h0, '0);
            expRnd = f[2] ? 3'(f) : {1'h1, globalRnd};
            check(convRound === expRnd, "conversion rounding");
        end
        $display("rounding test done");
        i_fcs_cpu_model.send(FCS_OP_SIG_CMP, 32'h3f80_0000, 32'h4000_0000, 3'h0, 1'h1, '0);
        settle(2);
        check(fsrRdData[19:16] === 4'h2, "killed compare retired");
        $display("kill test done");
        i_fcs_cpu_model.send(FCS_OP_CLASSIFY, 32'h7fa0_0000, 32'h0, 3'h0, 1'h0, '0);
        settle(2);
        check(fsrRdData[28:24] === 5'h01, "classify nan");
        check(nRaise === expRaise, "classify raised");
        i_fcs_cpu_model.send(FCS_OP_CLASSIFY, 32'h8000_0000, 32'h0, 3'h0, 1'h0, '0);
        settle(2);
        check(fsrRdData[28:24] === 5'h06, "classify negative zero");
        check(fsrRdData[19:16] === 4'h2, "classify touched order");
        $display("classify test done");
        excMask = 7'h10;
        i_fcs_cpu_model.send(FCS_OP_ARITH, 32'h3f80_0000, 32'h3f80_0000, 3'h0, 1'h0, 7'h10);
        check(excRaise === 1'h0 && excCause === 7'h00, "masked cause");
        settle(2);
        check(fsrRdData[4] === 1'h1 && fsrRdData[12] === 1'h1, "overflow flags");
        check(nRaise === expRaise, "masked exception raised");
        excMask = 7'h0;
        i_fcs_cpu_model.send(FCS_OP_ARITH, 32'h0000_0001, 32'h3f80_0000, 3'h0, 1'h0, '0);
        check(excRaise === 1'h1 && excCause === 7'h01, "unmasked cause");
        settle(2);
        check(fsrRdData[4] === 1'h0 && fsrRdData[12] === 1'h1, "sticky kept");
        check(fsrRdData[0] === 1'h1 && fsrRdData[8] === 1'h1, "tiny operand");
        check(nRaise === expRaise + 1, "unmasked exception");
        tinyAsZeroMode = 1'h1;
        i_fcs_cpu_model.send(FCS_OP_ARITH, 32'h0000_0001, 32'h3f80_0000, 3'h0, 1'h0, '0);
        settle(2);
        check(fsrRdData[0] === 1'h0, "tiny with zero mode");
        $display("exception test done");
        expRaise = nRaise;
        fsrWrEn = 1'h1;
        fsrWrData = 32'hffff_ffff;
        settle(1);
        fsrWrEn = 1'h0;
        check(fsrRdData === 32'h1f0f_7f7f, "software write");
        settle(3);
        check(nRaise === expRaise, "software write raised");
        $display("software write test done");
        fsrSnap = fsrRdData;
        i_fcs_cpu_model.send(FCS_OP_SILENT, 32'h7fa0_0000, 32'h0000_0001, 3'h0, 1'h0, 7'h7f);
        settle(2);
        check(fsrRdData === fsrSnap, "silent op changed status");
        check(nRaise === expRaise, "silent op raised");
        $display("silent op test done");
        rst_n = 1'h0;
        settle(2);
        check(fsrRdData === 32'h0 && convRound === 3'h4 && excRaise === 1'h0, "mid-run reset");
        check(predReady === 1'h1 && predVector === pred_of(4'h0), "reset predicates again");
        rst_n = 1'h1;
        i_fcs_cpu_model.send(FCS_OP_SIG_CMP, 32'h3f80_0000, 32'h4000_0000, 3'h0, 1'h0, '0);
        settle(2);
        check(fsrRdData[19:16] === 4'h4, "compare after reset");
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule
